/* File: rtl/bdr_pkg.sv */
// Shared constants and types for the multiplexed BCD digit readout.
// Assumes a single 10 MHz clock and a 32-bit AXI4-Lite register bus.
package bdr_pkg;

    // Timing: the scan clock is derived from the system clock.
    localparam int CLK_HZ        = 10_000_000;
    localparam int SCAN_HZ       = 4_000;
    localparam int SCAN_HALF_CYC = CLK_HZ / (2 * SCAN_HZ);

    // Display geometry.
    localparam int SCAN_DIGITS = 4;
    localparam int FIFO_DEPTH  = 16;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LATCH_OFS  = 8'h08;

    // Control register fields and reset value.
    localparam int         CTRL_EN_BIT = 0;
    localparam int         CTRL_DP_LSB = 4;
    localparam logic [2:0] DP_NONE     = 3'h7;
    localparam logic [7:0] CTRL_RESET  = 8'h71;

    // Status register field positions.
    localparam int STATUS_SLOT_LSB = 0;
    localparam int STATUS_XFER_BIT = 4;
    localparam int STATUS_LEVEL_LSB = 8;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One accumulated count as delivered by the counter chain.
    typedef struct packed {
        logic            sign_plus;
        logic [3:0]      lead;
        logic [3:0][3:0] digits;
    } bdr_count_t;

    // The static lines of the readout.
    typedef struct packed {
        logic one_n;
        logic polarity_n;
    } bdr_static_t;

endpackage

/* File: rtl/bdr_readout.sv */
// Multiplexed BCD digit readout with its input FIFO and AXI4-Lite registers.
// Assumes the counter chain offers counts by valid/ready on aclk and that the
// acquisition logic outside reads the pins on its own schedule.
// What this block does
// (R01) Scan digits LSD first, wrap after fourth.
// (R02) Leading digit, sign latched only at transfer.
// (R03) Scanned digits carry only values 0 to 9.
// (R04) Leading digit is 1 or 0, with sign.
// (R05) One segment decoder fed from shared BCD.
// (R06) One digit at a time, bits in parallel.
// (R07) 4 kHz scan clock advances slots, is output.
// (R08) Strobe high exactly during the LSD slot.
// (R09) Decimal point high for digit needing it.
// (R10) Transfer high while count copies into latches.
// (R11) Reader starts at first strobe after transfer.
// (R12) One line low when leading one lit.
// (R13) Polarity line low when plus shown.
// (R14) 8-4-2-1 active high, changes at slot edges.
// (R15) Reader samples once per slot from strobe.
`timescale 1ns/1ps

module bdr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output      logic             in_ready,
    output      logic [WIDTH-1:0] out_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("bdr_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_reg, wr_next;
    logic [AW:0]      rd_reg, rd_next;
    logic             push, pop;

    assign level     = wr_reg - rd_reg;
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (wr_reg != rd_reg);
    assign out_data  = mem_reg[rd_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

module bdr_readout #(
    parameter int SCAN_HALF  = bdr_pkg::SCAN_HALF_CYC,
    parameter int FIFO_WORDS = bdr_pkg::FIFO_DEPTH
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output      logic               s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output      logic               s_axi_wready,
    output      logic [1:0]         s_axi_bresp,
    output      logic               s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output      logic               s_axi_arready,
    output      logic [31:0]        s_axi_rdata,
    output      logic [1:0]         s_axi_rresp,
    output      logic               s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire bdr_pkg::bdr_count_t count_data,
    input  wire logic               count_valid,
    output      logic               count_ready,
    output      logic               scan_clk,
    output      logic [3:0]         bcd_out,
    output      logic [6:0]         seg_out,
    output      logic               lsd_strobe,
    output      logic               dp_out,
    output      logic               xfer_out,
    output      bdr_pkg::bdr_static_t static_out
);
    import bdr_pkg::*;

    localparam int DW = $clog2(SCAN_HALF);

    if (SCAN_HALF < 2 || SCAN_HALF > 4096) begin : g_bad_half
        $error("bdr_readout: SCAN_HALF out of range");
    end

    // Non-BCD codes are shown as zero so that no slot carries a value above nine.
    function automatic logic [3:0] bcd_clean(input logic [3:0] d);
        return (d > 4'h9) ? 4'h0 : d;
    endfunction

    // Segments a..g in bits 0..6, active high.
    function automatic logic [6:0] bcd_to_seg(input logic [3:0] d);
        case (d)
            4'h0:    return 7'h3f;
            4'h1:    return 7'h06;
            4'h2:    return 7'h5b;
            4'h3:    return 7'h4f;
            4'h4:    return 7'h66;
            4'h5:    return 7'h6d;
            4'h6:    return 7'h7d;
            4'h7:    return 7'h07;
            4'h8:    return 7'h7f;
            4'h9:    return 7'h6f;
            default: return 7'h00;
        endcase
    endfunction

    // Input FIFO between the counter chain and the holding latches.
    bdr_count_t                    fifo_data;
    logic                          fifo_valid;
    logic                          fifo_pop;
    logic [$clog2(FIFO_WORDS):0]   fifo_level;

    bdr_fifo #(.WIDTH($bits(bdr_count_t)), .DEPTH(FIFO_WORDS)) bdr_fifo_inst (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (count_data),
        .in_valid  (count_valid),
        .in_ready  (count_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .level     (fifo_level)
    );

    logic [7:0]  ctrl_reg, ctrl_next;
    logic        aw_got_reg, aw_got_next;
    logic [7:0]  aw_addr_reg, aw_addr_next;
    logic        w_got_reg, w_got_next;
    logic [31:0] w_data_reg, w_data_next;
    logic        w_strb_reg, w_strb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    logic [DW-1:0] div_reg, div_next;
    logic          sclk_reg, sclk_next;
    logic [1:0]    slot_reg, slot_next;
    logic          xfer_reg, xfer_next;
    bdr_count_t    hold_reg, hold_next;
    logic [3:0]    bcd_reg, bcd_next;
    logic [6:0]    seg_reg, seg_next;
    logic          lsd_reg, lsd_next;
    logic          dp_reg, dp_next;
    bdr_static_t   stat_reg, stat_next;
    logic          scan_rise;
    logic          aw_have, w_have;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign aw_have       = aw_got_reg || (s_axi_awvalid && s_axi_awready);
    assign w_have        = w_got_reg || (s_axi_wvalid && s_axi_wready);

    always_comb begin
        ctrl_next    = ctrl_reg;
        aw_got_next  = aw_got_reg;
        aw_addr_next = aw_addr_reg;
        w_got_next   = w_got_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_next  = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_next  = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb[0];
        end
        // The write completes once address and data are both held.
        if (aw_have && w_have) begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            if ({aw_addr_next[7:2], 2'b00} == CTRL_OFS) begin
                if (w_strb_next) begin
                    ctrl_next = w_data_next[7:0];
                end
            end else if ({aw_addr_next[7:2], 2'b00} != STATUS_OFS && {aw_addr_next[7:2], 2'b00} != LATCH_OFS) begin
                bresp_next = RESP_SLVERR;
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0;
            case ({s_axi_araddr[7:2], 2'b00})
                CTRL_OFS: rdata_next[7:0] = ctrl_reg;
                STATUS_OFS: begin
                    rdata_next[STATUS_SLOT_LSB +: 2]                    = slot_reg;
                    rdata_next[STATUS_XFER_BIT]                         = xfer_reg;
                    rdata_next[STATUS_LEVEL_LSB +: $bits(fifo_level)]   = fifo_level;
                end
                LATCH_OFS: rdata_next[$bits(bdr_count_t)-1:0] = hold_reg;
                default: rresp_next = RESP_SLVERR;
            endcase
        end
    end

    // Slot advance happens on the rising edge of the scan clock.
    assign scan_rise = ctrl_reg[CTRL_EN_BIT] && (div_reg == DW'(SCAN_HALF - 1)) && !sclk_reg;

    always_comb begin
        div_next  = div_reg;
        sclk_next = sclk_reg;
        slot_next = slot_reg;
        xfer_next = xfer_reg;
        hold_next = hold_reg;
        fifo_pop  = 1'b0;
        if (ctrl_reg[CTRL_EN_BIT]) begin
            div_next = (div_reg == DW'(SCAN_HALF - 1)) ? '0 : div_reg + 1'b1; // R07
            sclk_next = sclk_reg ^ (div_reg == DW'(SCAN_HALF - 1)); // R07
        end
        if (scan_rise) begin
            slot_next = (slot_reg == 2'(SCAN_DIGITS - 1)) ? 2'h0 : slot_reg + 1'b1; // R01
            // Transfer spans the whole last slot so the copy lands on a slot edge.
            if (slot_next == 2'(SCAN_DIGITS - 1) && fifo_valid) begin
                xfer_next = 1'b1; // R10
            end
            if (slot_reg == 2'(SCAN_DIGITS - 1) && xfer_reg) begin
                xfer_next           = 1'b0; // R10
                fifo_pop            = 1'b1;
                hold_next.sign_plus = fifo_data.sign_plus; // R02
                hold_next.lead      = (fifo_data.lead != 4'h0) ? 4'h1 : 4'h0; // R04
                for (int i = 0; i < SCAN_DIGITS; i++) begin
                    hold_next.digits[i] = bcd_clean(fifo_data.digits[i]); // R03
                end
            end
        end
        bcd_next             = hold_next.digits[slot_next]; // R06 R14
        seg_next             = bcd_to_seg(bcd_next); // R05
        lsd_next             = (slot_next == 2'h0); // R08
        dp_next              = (ctrl_reg[CTRL_DP_LSB +: 3] == {1'b0, slot_next}); // R09
        stat_next.one_n      = !(hold_next.lead == 4'h1); // R12
        stat_next.polarity_n = !hold_next.sign_plus; // R13
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= CTRL_RESET;
            aw_got_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_got_reg   <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= RESP_OKAY;
            div_reg     <= '0;
            sclk_reg    <= 1'b0;
            slot_reg    <= 2'h0;
            xfer_reg    <= 1'b0;
            hold_reg    <= '0;
            bcd_reg     <= 4'h0;
            seg_reg     <= 7'h3f;
            lsd_reg     <= 1'b1;
            dp_reg      <= 1'b0;
            stat_reg    <= 2'h3;
        end else begin
            ctrl_reg    <= ctrl_next;
            aw_got_reg  <= aw_got_next;
            aw_addr_reg <= aw_addr_next;
            w_got_reg   <= w_got_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            div_reg     <= div_next;
            sclk_reg    <= sclk_next;
            slot_reg    <= slot_next;
            xfer_reg    <= xfer_next;
            hold_reg    <= hold_next;
            bcd_reg     <= bcd_next;
            seg_reg     <= seg_next;
            lsd_reg     <= lsd_next;
            dp_reg      <= dp_next;
            stat_reg    <= stat_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
    assign scan_clk     = sclk_reg;
    assign bcd_out      = bcd_reg;
    assign seg_out      = seg_reg;
    assign lsd_strobe   = lsd_reg;
    assign dp_out       = dp_reg;
    assign xfer_out     = xfer_reg;
    assign static_out   = stat_reg;
endmodule

/* File: verification/bdr_readout_props.sv */
// Concurrent checks on the display pins of the digit readout.
// Assumes it is bound into bdr_readout and sees only its ports.
`timescale 1ns/1ps
module bdr_readout_props
    import bdr_pkg::*;
#(
    parameter int SCAN_HALF = 4
) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 scan_clk,
    input wire logic [3:0]           bcd_out,
    input wire logic [6:0]           seg_out,
    input wire logic                 lsd_strobe,
    input wire logic                 xfer_out,
    input wire bdr_pkg::bdr_static_t static_out
);
    localparam logic [6:0] SEG [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                        7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    logic prev_reg;
    logic seen_reg;
    logic seen_next;
    logic chg;
    int   cnt_reg;
    int   cnt_next;

    // The first edge after reset has no full half period behind it, so it is skipped.
    assign chg = scan_clk != prev_reg;
    always_comb begin
        seen_next = seen_reg | chg;
        cnt_next = chg ? 1 : cnt_reg + 1;
        if (!aresetn) begin
            seen_next = 1'b0;
            cnt_next = 0;
        end
    end
    always_ff @(posedge aclk) begin
        prev_reg <= scan_clk;
        seen_reg <= seen_next;
        cnt_reg <= cnt_next;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bcd_range: assert property (bcd_out <= 4'h9)
        else $error("digit value above nine");
    a_seg_decode: assert property (bcd_out <= 4'h9 |-> seg_out == SEG[bcd_out])
        else $error("segments do not match digit");
    a_bcd_slot_edge: assert property ($changed(bcd_out) |-> $rose(scan_clk))
        else $error("digit changed inside a slot");
    a_strobe_edge: assert property ($changed(lsd_strobe) |-> $rose(scan_clk))
        else $error("strobe moved off a slot edge");
    a_half_period: assert property (chg && seen_reg |-> cnt_reg == SCAN_HALF)
        else $error("scan clock half period wrong");
    a_static_copy: assert property ($changed(static_out) |-> $rose(lsd_strobe))
        else $error("static lines changed outside a copy");
    a_xfer_rise: assert property ($rose(xfer_out) |-> $rose(scan_clk) && !lsd_strobe)
        else $error("transfer rose off a slot edge");
    a_xfer_fall: assert property ($fell(xfer_out) |-> $rose(lsd_strobe) && $rose(scan_clk))
        else $error("transfer ended without a new first slot");

    c_xfer: cover property ($rose(xfer_out));
    c_copy: cover property ($changed(static_out));
    c_frame: cover property (lsd_strobe && $rose(scan_clk));
endmodule

bind bdr_readout bdr_readout_props #(.SCAN_HALF(SCAN_HALF)) bdr_readout_props_inst (
    .aclk(aclk), .aresetn(aresetn), .scan_clk(scan_clk), .bcd_out(bcd_out),
    .seg_out(seg_out), .lsd_strobe(lsd_strobe), .xfer_out(xfer_out), .static_out(static_out));

/* File: verification/bdr_reader.sv */
// Model of the acquisition logic that reads the digit pins.
// Assumes pins settle between aclk edges; it samples them on the falling edge.
`timescale 1ns/1ps
module bdr_reader
    import bdr_pkg::*;
(
    input wire logic                  aclk,
    input wire logic                  scan_clk,
    input wire logic [3:0]            bcd_out,
    input wire logic                  lsd_strobe,
    input wire logic                  dp_out,
    input wire logic                  xfer_out,
    input wire bdr_pkg::bdr_static_t  static_out,
    output     bdr_pkg::bdr_count_t   reading,
    output     logic [3:0]            dp_mask,
    output     int                    n_read
);
    logic       sc_d = 1'b0;
    logic       xf_d = 1'b0;
    logic       armed = 1'b0;
    logic       go = 1'b0;
    int         idx = 0;
    logic [3:0] m;
    bdr_count_t acc;

    initial n_read = 0;
    // Sampling at the falling scan edge lands mid-slot, away from digit changes.
    always @(negedge aclk) begin
        if (xf_d && !xfer_out) armed = 1'b1;
        if (sc_d && !scan_clk) begin
            idx = lsd_strobe ? 0 : idx + 1;
            if (lsd_strobe && armed) begin
                go = 1'b1;
                armed = 1'b0;
            end
            if (go && idx < 4) begin
                acc.digits[idx] = bcd_out;
                m[idx] = dp_out;
            end
            if (go && idx == 3) begin
                acc.lead = {3'h0, !static_out.one_n};
                acc.sign_plus = !static_out.polarity_n;
                reading = acc;
                dp_mask = m;
                n_read++;
                go = 1'b0;
            end
        end
        xf_d = xfer_out;
        sc_d = scan_clk;
    end
endmodule

/* File: verification/bdr_readout_tb.sv */
// Self-checking bench: registers over AXI4-Lite, counts streamed in, pins read back.
// Assumes a 10 MHz clock and a scan half period shortened to 4 cycles.
`timescale 1ns/1ps
module bdr_readout_tb;
    import bdr_pkg::*;
    localparam int HALF = 4;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, count_valid, count_ready, scan_clk, lsd, dp, xfer;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed, d, d2;
    logic [3:0]  wstrb, bcd, mask;
    logic [1:0]  bresp, rresp, r;
    logic [6:0]  seg;
    logic [2:0]  dpv;
    bdr_count_t  count_data, reading, w, last;
    bdr_static_t st;
    int          n_read, n_mismatch, checks_done, base, nacc;
    logic        full;

    bdr_readout #(.SCAN_HALF(HALF)) bdr_readout_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_data(count_data), .count_valid(count_valid), .count_ready(count_ready),
        .scan_clk(scan_clk), .bcd_out(bcd), .seg_out(seg), .lsd_strobe(lsd), .dp_out(dp),
        .xfer_out(xfer), .static_out(st));
    bdr_reader bdr_reader_inst (.aclk(aclk), .scan_clk(scan_clk), .bcd_out(bcd), .lsd_strobe(lsd),
        .dp_out(dp), .xfer_out(xfer), .static_out(st), .reading(reading), .dp_mask(mask),
        .n_read(n_read));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Non-decimal digits read back as zero and any nonzero leading digit as one.
    function bdr_count_t expect_of(input bdr_count_t x);
        bdr_count_t e;
        e = x;
        for (int k = 0; k < 4; k++) if (x.digits[k] > 4'h9) e.digits[k] = 4'h0;
        e.lead = {3'h0, x.lead != 4'h0};
        return e;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task push(input bdr_count_t x);
        @(posedge aclk);
        count_data <= x;
        count_valid <= 1'b1;
        do @(negedge aclk); while (!count_ready);
        @(posedge aclk);
        count_valid <= 1'b0;
    endtask
    task wait_read(input int target, input int limit);
        int k;
        k = 0;
        while (n_read < target && k < limit) begin
            @(posedge aclk);
            k++;
        end
        chk(k < limit, 1, "reading arrived");
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        results;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, count_valid} = '0;
        {awaddr, araddr, wdata, wstrb, count_data} = '0;
        n_mismatch = 0;
        checks_done = 0;
        nacc = 0;
        seed = 32'h7336e4e5;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFS, d, r);
        chk(d, 32'h71, "control reset value");
        axi_rd(8'h0c, d, r);
        chk(r, RESP_SLVERR, "unmapped read");
        axi_wr(8'h10, 32'h0, r);
        chk(r, RESP_SLVERR, "unmapped write");
        for (int i = 0; i < 6; i++) begin
            dpv = (i == 4) ? DP_NONE : 3'(i % 4);
            axi_wr(CTRL_OFS, {25'h0, dpv, 4'h1}, r);
            chk(r, RESP_OKAY, "control write response");
            seed = lfsr(seed);
            w = (i == 0) ? 21'h009af : (i == 1) ? {1'b1, 4'hf, 16'h9999} : seed[20:0];
            base = n_read;
            push(w);
            wait_read(base + 1, 400);
            chk(reading, expect_of(w), "reading");
            chk(mask, (dpv == DP_NONE) ? 4'h0 : 4'h1 << dpv, "decimal point slot");
        end
        // Stream without gaps until the buffer refuses, then hold the refused word until taken.
        base = n_read;
        full = 1'b0;
        seed = lfsr(seed);
        @(posedge aclk);
        count_valid <= 1'b1;
        count_data <= seed[20:0];
        for (int k = 0; k < 40 && !full; k++) begin
            @(negedge aclk);
            full = !count_ready;
            if (!full) nacc++;
            if (!full) last = count_data;
            @(posedge aclk);
            seed = lfsr(seed);
            if (!full) count_data <= seed[20:0];
        end
        chk(full, 1, "buffer refuses when full");
        do @(negedge aclk); while (!count_ready);
        nacc++;
        last = count_data;
        @(posedge aclk);
        count_valid <= 1'b0;
        wait_read(base + nacc, 2000);
        chk(n_read - base, nacc, "one reading per word");
        chk(reading, expect_of(last), "last reading in order");
        axi_rd(STATUS_OFS, d, r);
        chk(d[12:8], 5'h0, "buffer drained");
        chk(r, RESP_OKAY, "status read response");
        // With the enable cleared the slot must not move; running, it would have moved at least one slot.
        axi_wr(CTRL_OFS, 32'h70, r);
        axi_rd(STATUS_OFS, d, r);
        repeat (3 * HALF) @(posedge aclk);
        axi_rd(STATUS_OFS, d2, r);
        chk(d2[1:0], d[1:0], "scan frozen when disabled");
        results;
    end
endmodule
